// File: stage_pkg.sv
// Constants and types shared by the programmable stage comparator files.
// Assumes a 50 MHz clock and a program-cycle tick supplied from outside.
package stage_pkg;
   localparam int unsigned CLK_HZ         = 50_000_000;  // Core clock rate
   localparam int unsigned DELTA_WIN_MS   = 20;          // Change-detection window, ms
   localparam int unsigned DELTA_WIN_CYC  = CLK_HZ / 1000 * DELTA_WIN_MS; // Window in clocks
   localparam int unsigned MEAS_W         = 32;          // Signed measurement width
   localparam int unsigned HYST_W         = 16;          // Hysteresis, units of 0.01 %
   localparam logic [15:0] HYST_RESET     = 16'h012C;    // 3.00 % after reset
   localparam int unsigned HYST_SCALE     = 10000;       // Hysteresis full scale (100 %)
   localparam int unsigned PCT_SCALE      = 10000;       // Relative pick-up full scale
   localparam int unsigned TIMER_W        = 24;          // Delay counters in program cycles
   localparam int unsigned LOG_DEPTH      = 12;          // Retained log entries
   localparam int unsigned TS_W           = 32;          // Time-stamp width
   localparam logic [1:0]  EVSEL_ON       = 2'h1;        // Store on-transitions
   localparam logic [1:0]  EVSEL_OFF      = 2'h2;        // Store off-transitions
   localparam logic [1:0]  COND_NORMAL    = 2'h0;        // Status codes
   localparam logic [1:0]  COND_START     = 2'h1;
   localparam logic [1:0]  COND_TRIP      = 2'h2;
   localparam logic [1:0]  COND_BLOCKED   = 2'h3;
   localparam logic [1:0]  EVK_START      = 2'h0;        // Event kinds
   localparam logic [1:0]  EVK_TRIP       = 2'h1;
   localparam logic [1:0]  EVK_BLOCK      = 2'h2;

   // Comparator modes, codes 0..7 follow the declaration order
   typedef enum logic [2:0] {
      CMP_OVER, CMP_OVER_ABS, CMP_UNDER, CMP_UNDER_ABS,
      CMP_DELTA_PCT, CMP_DELTA_PCT_ABS, CMP_DELTA_VAL, CMP_DELTA_VAL_ABS
   } cmp_mode_t;

   // Magnitude of a signed value, widened so the most negative input is safe
   function automatic logic signed [MEAS_W:0] abs_val(input logic signed [MEAS_W-1:0] v);
      logic signed [MEAS_W:0] w;
      w = {v[MEAS_W-1], v};
      abs_val = (w < 0) ? -w : w;
   endfunction : abs_val
endpackage : stage_pkg

// File: stage_compare.sv
// Threshold comparator with hysteresis for one stage.
// Assumes prev_meas holds the value seen one change window earlier.
`timescale 1ns/10ps
module stage_compare
   import stage_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     rst_b,
   input  wire logic                     clk_en,
   input  wire logic                     eval,         // Program-cycle strobe
   input  wire cmp_mode_t                mode,
   input  wire logic signed [MEAS_W-1:0] meas,
   input  wire logic signed [MEAS_W-1:0] prev_meas,
   input  wire logic signed [MEAS_W-1:0] pickup,       // Signed pick-up level
   input  wire logic [HYST_W-1:0]        hyst,
   input  wire logic signed [MEAS_W-1:0] block_limit,  // Under-mode blocking limit
   output logic                          pickup_q      // Comparison fulfilled
);
   logic signed [MEAS_W+1:0]  x;       // Compared quantity
   logic signed [MEAS_W+1:0]  thr;     // Threshold magnitude or level
   logic signed [MEAS_W+1:0]  band;    // Hysteresis band
   logic signed [MEAS_W+33:0] prod;    // Wide scratch product
   logic                      over_d;  // Over-type operation
   logic                      inhibit; // Under blocking limit active
   logic                      pickup_d;

   // Select quantity and threshold per mode
   always_comb begin
      prod    = '0;
      x       = '0;
      thr     = pickup;
      over_d  = 1'b1;
      inhibit = 1'b0;
      case (mode)
         CMP_OVER:      x = meas;
         CMP_OVER_ABS:  x = abs_val(meas);
         CMP_UNDER: begin
            x = meas;
            over_d = 1'b0;
            inhibit = meas < block_limit;
         end
         CMP_UNDER_ABS: begin
            x = abs_val(meas);
            over_d = 1'b0;
            inhibit = meas < block_limit;
         end
         CMP_DELTA_PCT, CMP_DELTA_PCT_ABS: begin
            // Relative pick-up is a fraction of the earlier value
            x = (mode == CMP_DELTA_PCT) ? meas - prev_meas
                                        : abs_val(meas) - abs_val(prev_meas);
            if (mode == CMP_DELTA_PCT_ABS) x = (x < 0) ? -x : x;
            prod = abs_val(prev_meas) * pickup;
            thr  = (MEAS_W+2)'(prod / $signed(PCT_SCALE));
         end
         CMP_DELTA_VAL: x = meas - prev_meas;
         CMP_DELTA_VAL_ABS: begin
            x = meas - prev_meas;
            x = (x < 0) ? -x : x;
         end
         default: x = meas;
      endcase
      // Band is relative to the pick-up magnitude, never an offset
      band = (MEAS_W+2)'(((thr < 0) ? -thr : thr) * $signed({1'b0, hyst}) / HYST_SCALE);
   end

   // Hysteresis: release only once back past the level by the band
   always_comb begin
      if (inhibit)
         pickup_d = 1'b0;
      else if (over_d)
         pickup_d = pickup_q ? (x > thr - band) : (x > thr);
      else
         pickup_d = pickup_q ? (x < thr + band) : (x < thr);
   end

   // Update once per program cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         pickup_q <= 1'b0;
      else if (clk_en && eval)
         pickup_q <= pickup_d;
   end
endmodule : stage_compare

// File: stage_log.sv
// Circular log of the most recent on-events with their process data.
// Assumes one write strobe per recorded on-event.
`timescale 1ns/10ps
module stage_log
   import stage_pkg::*;
#(
   parameter int unsigned DEPTH = LOG_DEPTH
)(
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              clk_en,
   input  wire logic              wr,
   input  wire logic [1:0]        wr_kind,
   input  wire logic [TS_W-1:0]   wr_time,
   input  wire logic [MEAS_W-1:0] wr_meas,
   input  wire logic [3:0]        rd_idx,     // 0 is newest entry
   output logic [1:0]             rd_kind,
   output logic [TS_W-1:0]        rd_time,
   output logic [MEAS_W-1:0]      rd_meas,
   output logic [4:0]             count_q     // Entries held, saturates at DEPTH
);
   logic [1:0]        kind_mem [DEPTH];   // Event kind per entry
   logic [TS_W-1:0]   time_mem [DEPTH];   // Time stamp per entry
   logic [MEAS_W-1:0] meas_mem [DEPTH];   // Measured value per entry
   logic [3:0]        wp_q;               // Next slot to overwrite
   logic [3:0]        slot;

   // Write pointer wraps so the oldest entry is dropped
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wp_q    <= 4'h0;
         count_q <= 5'h00;
      end else if (clk_en && wr) begin
         wp_q    <= (wp_q == 4'(DEPTH - 1)) ? 4'h0 : wp_q + 4'h1;
         if (count_q != 5'(DEPTH)) count_q <= count_q + 5'h01;
      end
   end

   // Storage needs no reset; count_q says what is valid
   always_ff @(posedge clk) begin
      if (clk_en && wr) begin
         kind_mem[wp_q] <= wr_kind;
         time_mem[wp_q] <= wr_time;
         meas_mem[wp_q] <= wr_meas;
      end
   end

   // Newest-first read index
   always_comb begin
      slot = (rd_idx < wp_q) ? wp_q - rd_idx - 4'h1 : 4'(DEPTH) + wp_q - rd_idx - 4'h1;
      if (slot >= 4'(DEPTH)) slot = 4'h0;
   end

   // Registered read data
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_kind <= 2'h0;
         rd_time <= '0;
         rd_meas <= '0;
      end else if (clk_en) begin
         rd_kind <= kind_mem[slot];
         rd_time <= time_mem[slot];
         rd_meas <= meas_mem[slot];
      end
   end
endmodule : stage_log

// File: programmable_stage_block.sv
// One programmable protection stage: comparator, blocking, delays, events, log.
// Assumes cycle_tick pulses once per program cycle and time_now is a running time stamp.
//
// Functional notes
// - Mode 0: signed value above pick-up
// - Mode 1: absolute value above pick-up
// - Mode 2: signed value below pick-up
// - Mode 3: absolute value below pick-up
// - Under modes inhibited below blocking limit
// - Mode 4: signed relative change in window
// - Mode 5: unsigned relative change in window
// - Mode 6: signed absolute change in window
// - Mode 7: unsigned absolute change in window
// - Signed pick-up level per comparison
// - Independent hysteresis, three percent default
// - Separate operate and release delays
// - Block input sampled at cycle start
// - Unblocked pick-up starts and times trip
// - Blocked pick-up flags blocked; no start, no trip
// - Blocking clears start, runs release delay
// - Blocking raises notification, and block event unless a selected start or trip off-event wins that cycle
// - Events on start, trip, blocked changes
// - Select on, off, or both events
// - Events carry time stamp and data
// - Keep last twelve on-event log entries
// - Hysteresis relative to pick-up magnitude
// - Status code normal/start/trip/blocked 0..3
`timescale 1ns/10ps
module programmable_stage_block
   import stage_pkg::*;
#(
   parameter int unsigned WIN_CYC = DELTA_WIN_CYC   // Change window in clocks
)(
   input  wire logic                     clk,
   input  wire logic                     rst_b,
   input  wire logic                     clk_en,       // Freezes all state when low
   input  wire logic                     cycle_tick,   // Program-cycle start pulse
   input  wire logic                     block_in,     // From blocking matrix
   input  wire logic signed [MEAS_W-1:0] meas,         // Scaled measurement
   input  wire logic [TS_W-1:0]          time_now,     // Running time stamp
   input  wire cmp_mode_t                mode,
   input  wire logic signed [MEAS_W-1:0] pickup,
   input  wire logic [HYST_W-1:0]        hyst,
   input  wire logic signed [MEAS_W-1:0] block_limit,
   input  wire logic [TIMER_W-1:0]       op_delay,     // Operate delay, cycles
   input  wire logic [TIMER_W-1:0]       rel_delay,    // Release delay, cycles
   input  wire logic [1:0]               ev_select,    // Bit0 on, bit1 off
   input  wire logic [3:0]               log_idx,
   output logic                          start_q,
   output logic                          trip_q,
   output logic                          blocked_q,
   output logic [1:0]                    cond_q,       // Status code
   output logic                          notify_q,     // Display notification pulse
   output logic                          ev_valid_q,   // Event pulse
   output logic [1:0]                    ev_kind_q,
   output logic                          ev_on_q,      // 1 on, 0 off
   output logic [TS_W-1:0]               ev_time_q,
   output logic signed [MEAS_W-1:0]      ev_meas_q,
   output logic signed [MEAS_W-1:0]      ev_pickup_q,  // Startup value context
   output cmp_mode_t                     ev_mode_q,    // Fault type context
   output logic [1:0]                    log_kind,
   output logic [TS_W-1:0]               log_time,
   output logic [MEAS_W-1:0]             log_meas,
   output logic [4:0]                    log_count
);
   logic                     blk_q;         // Block input as seen this cycle
   logic                     eval_q;        // Evaluate one clock after tick
   logic                     pick;          // Comparator output
   logic signed [MEAS_W-1:0] win_q;         // Value captured at window start
   logic [31:0]              win_cnt_q;     // Window clock counter
   logic [TIMER_W-1:0]       op_cnt_q;      // Operate timer
   logic [TIMER_W-1:0]       rel_cnt_q;     // Release timer
   logic                     releasing_q;   // Release delay running
   logic                     start_d;
   logic                     trip_d;
   logic                     blocked_d;
   logic [2:0]               rise;          // start, trip, blocked rising
   logic [2:0]               fall;
   logic                     log_wr;
   logic [1:0]               log_k;

   // Block input is latched at cycle start, on the same edge as the comparator update
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         blk_q  <= 1'b0;
         eval_q <= 1'b0;
      end else if (clk_en) begin
         if (cycle_tick) blk_q <= block_in;
         eval_q <= cycle_tick;
      end
   end

   // Capture the value at each change-window start
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         win_cnt_q <= 32'h0;
         win_q     <= '0;
      end else if (clk_en) begin
         if (win_cnt_q >= WIN_CYC - 1) begin
            win_cnt_q <= 32'h0;
            win_q     <= meas;
         end else begin
            win_cnt_q <= win_cnt_q + 32'h1;
         end
      end
   end

   stage_compare u_cmp (
      .clk         (clk),
      .rst_b       (rst_b),
      .clk_en      (clk_en),
      .eval        (cycle_tick),
      .mode        (mode),
      .meas        (meas),
      .prev_meas   (win_q),
      .pickup      (pickup),
      .hyst        (hyst),
      .block_limit (block_limit),
      .pickup_q    (pick)
   );

   // Next state of the indications, one evaluation per program cycle
   always_comb begin
      start_d   = start_q;
      trip_d    = trip_q;
      blocked_d = blocked_q;
      if (pick && blk_q) begin
         // Blocked pick-up: no start, no trip; the release delay still runs
         blocked_d = 1'b1;
         start_d   = 1'b0;
      end else if (pick) begin
         blocked_d = 1'b0;
         start_d   = 1'b1;
         if (op_cnt_q + 1'b1 >= op_delay) trip_d = 1'b1;
      end else begin
         blocked_d = 1'b0;
         start_d   = 1'b0;
      end
      // Trip holds until the release delay has run out
      if (!start_d && trip_q && releasing_q && rel_cnt_q + 1'b1 >= rel_delay)
         trip_d = 1'b0;
      if (!start_d && trip_q && !releasing_q && rel_delay == '0)
         trip_d = 1'b0;
   end

   // Operate and release timers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         op_cnt_q    <= '0;
         rel_cnt_q   <= '0;
         releasing_q <= 1'b0;
      end else if (clk_en && eval_q) begin
         if (start_d) begin
            if (!trip_d) op_cnt_q <= op_cnt_q + 1'b1;
            rel_cnt_q   <= '0;
            releasing_q <= 1'b0;
         end else begin
            op_cnt_q <= '0;
            // Blocking takes the same release path as a drop-out
            releasing_q <= trip_d;
            rel_cnt_q   <= trip_d ? rel_cnt_q + 1'b1 : '0;
         end
      end
   end

   // Indication registers and status code
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         start_q   <= 1'b0;
         trip_q    <= 1'b0;
         blocked_q <= 1'b0;
         cond_q    <= COND_NORMAL;
      end else if (clk_en && eval_q) begin
         start_q   <= start_d;
         trip_q    <= trip_d;
         blocked_q <= blocked_d;
         // Trip outranks start, blocked shows only alone
         if (trip_d)         cond_q <= COND_TRIP;
         else if (start_d)   cond_q <= COND_START;
         else if (blocked_d) cond_q <= COND_BLOCKED;
         else                cond_q <= COND_NORMAL;
      end
   end

   assign rise = {blocked_d & ~blocked_q, trip_d & ~trip_q, start_d & ~start_q};
   assign fall = {~blocked_d & blocked_q, ~trip_d & trip_q, ~start_d & start_q};

   // Event emission: one per cycle, priority trip, start, block
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ev_valid_q  <= 1'b0;
         ev_kind_q   <= EVK_START;
         ev_on_q     <= 1'b0;
         ev_time_q   <= '0;
         ev_meas_q   <= '0;
         ev_pickup_q <= '0;
         ev_mode_q   <= CMP_OVER;
         notify_q    <= 1'b0;
      end else if (clk_en) begin
         ev_valid_q <= 1'b0;
         notify_q   <= 1'b0;
         if (eval_q) begin
            notify_q <= rise[2];
            if ((rise[1] && ev_select[0]) || (fall[1] && ev_select[1])) begin
               ev_valid_q <= 1'b1;
               ev_kind_q  <= EVK_TRIP;
               ev_on_q    <= rise[1];
            end else if ((rise[0] && ev_select[0]) || (fall[0] && ev_select[1])) begin
               ev_valid_q <= 1'b1;
               ev_kind_q  <= EVK_START;
               ev_on_q    <= rise[0];
            end else if ((rise[2] && ev_select[0]) || (fall[2] && ev_select[1])) begin
               ev_valid_q <= 1'b1;
               ev_kind_q  <= EVK_BLOCK;
               ev_on_q    <= rise[2];
            end
            ev_time_q   <= time_now;
            ev_meas_q   <= meas;
            ev_pickup_q <= pickup;
            ev_mode_q   <= mode;
         end
      end
   end

   // Log takes on-events of start, trip and blocked regardless of selection
   assign log_wr = clk_en & eval_q & (|rise);
   assign log_k  = rise[1] ? EVK_TRIP : (rise[0] ? EVK_START : EVK_BLOCK);

   stage_log u_log (
      .clk     (clk),
      .rst_b   (rst_b),
      .clk_en  (clk_en),
      .wr      (log_wr),
      .wr_kind (log_k),
      .wr_time (time_now),
      .wr_meas (meas),
      .rd_idx  (log_idx),
      .rd_kind (log_kind),
      .rd_time (log_time),
      .rd_meas (log_meas),
      .count_q (log_count)
   );
endmodule : programmable_stage_block

// File: stage_checker_properties.sv
// Port assertions for one programmable stage.
// Bound to programmable_stage_block; sees only its ports.
`timescale 1ns/10ps
module stage_checker
   import stage_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       clk_en,
   input wire logic       cycle_tick,
   input wire logic       block_in,
   input wire logic [1:0] ev_select,
   input wire logic       start_q,
   input wire logic       trip_q,
   input wire logic       blocked_q,
   input wire logic [1:0] cond_q,
   input wire logic       notify_q,
   input wire logic       ev_valid_q,
   input wire logic [1:0] ev_kind_q,
   input wire logic       ev_on_q,
   input wire logic [4:0] log_count
);
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Blocked tick, clock still enabled for the update edge
   sequence blk_tick; cycle_tick && clk_en && block_in ##1 clk_en; endsequence
   // Start rising alone, so its event is not pre-empted by trip
   sequence start_rise; $rose(start_q) && !$changed(trip_q) && clk_en && ev_select[0]; endsequence
   a_block_clears_start: assert property (blk_tick |-> ##1 !start_q)
      else $error("start high after blocked tick");
   a_start_blk_excl: assert property (!(start_q && blocked_q))
      else $error("start and blocked together");
   a_cond_normal: assert property (
      !(start_q || trip_q || blocked_q) |-> cond_q == COND_NORMAL)
      else $error("idle status code wrong");
   a_cond_start: assert property (start_q && !trip_q |-> cond_q == COND_START)
      else $error("start status code wrong");
   a_notify_pulse: assert property (
      $rose(blocked_q) |-> ##[0:1] (notify_q ##1 !notify_q))
      else $error("no single notification on blocking");
   a_start_event: assert property (
      start_rise |-> ev_valid_q && ev_on_q && ev_kind_q == EVK_START)
      else $error("missing start on-event");
   a_event_filter: assert property (
      ev_valid_q |-> (ev_on_q ? ev_select[0] : ev_select[1]))
      else $error("event stored against selection");
   a_event_pulse: assert property (ev_valid_q |=> !ev_valid_q)
      else $error("event valid too long");
   a_log_step: assert property (
      $rose(start_q) && !$rose(trip_q) && $past(log_count) < LOG_DEPTH
      |-> log_count == $past(log_count) + 5'h01)
      else $error("log entry not added");
   a_log_limit: assert property (log_count <= LOG_DEPTH)
      else $error("log count beyond depth");
   a_frozen_state: assert property (
      !clk_en |=> $stable({start_q, trip_q, blocked_q, log_count}))
      else $error("state moved while frozen");
endmodule : stage_checker

bind programmable_stage_block stage_checker u_stage_checker (
   .clk, .rst_b, .clk_en, .cycle_tick, .block_in, .ev_select, .start_q, .trip_q,
   .blocked_q, .cond_q, .notify_q, .ev_valid_q, .ev_kind_q, .ev_on_q, .log_count);

// File: stage_env_model.sv
// Far-side model: program-cycle ticker, time base and event buffer tally.
// Assumes one clock; ticker and time base move on the falling edge, the tally on the rising edge.
`timescale 1ns/10ps
module stage_env_model
   import stage_pkg::*;
#(
   parameter int unsigned GAP = 4 // Clocks per program cycle, 3 or more
)(
   input  wire logic            clk,
   input  wire logic            rst_b,
   input  wire logic            ev_valid,
   input  wire logic            ev_on,
   input  wire logic [TS_W-1:0] ev_time,
   output logic                 cycle_tick,
   output logic [TS_W-1:0]      time_now,
   output int                   n_on,
   output int                   n_off,
   output logic [TS_W-1:0]      age
);
   int cnt; // Clocks into the current cycle
   // Ticker and time base; the falling edge keeps them clear of sampling
   always @(negedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 0;
         cycle_tick <= 1'b0;
         time_now <= 32'h0;
      end else begin
         cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
         cycle_tick <= (cnt == GAP - 1);
         time_now <= time_now + 32'h1;
      end
   end
   // Event buffer: tally stored records and age of the last time stamp
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         n_on <= 0;
         n_off <= 0;
         age <= 32'h0;
      end else if (ev_valid) begin
         if (ev_on) n_on <= n_on + 1;
         else n_off <= n_off + 1;
         age <= time_now - ev_time;
      end
   end
endmodule : stage_env_model

// File: tb_programmable_stage_block.sv
// Bench for one stage: modes, hysteresis, blocking, events, log, freeze.
// Needs stage_env_model and the bound checker.
`timescale 1ns/10ps
module tb_programmable_stage_block
   import stage_pkg::*;
;
   logic clk, rst_b, clk_en, block_in, cycle_tick, start_q, trip_q, blocked_q;
   logic ev_valid_q, ev_on_q;
   logic signed [MEAS_W-1:0] meas, pickup, block_limit, ev_meas_q, ev_pickup_q;
   logic [MEAS_W-1:0] log_meas;
   logic [TS_W-1:0] time_now, ev_time_q, age, log_time;
   logic [TIMER_W-1:0] op_delay, rel_delay;
   logic [HYST_W-1:0] hyst;
   logic [1:0] ev_select, cond_q, log_kind;
   logic [3:0] log_idx;
   logic [4:0] log_count;
   cmp_mode_t mode, ev_mode_q;
   int n_on, n_off;
   int fail_count = 0, n_tests = 0;

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Window shortened to 16 clocks so change modes show in a short run
   programmable_stage_block #(.WIN_CYC(16)) u_programmable_stage_block (
      .clk, .rst_b, .clk_en, .cycle_tick, .block_in, .meas, .time_now, .mode, .pickup,
      .hyst, .block_limit, .op_delay, .rel_delay, .ev_select, .log_idx, .start_q,
      .trip_q, .blocked_q, .cond_q, .notify_q(), .ev_valid_q, .ev_kind_q(), .ev_on_q,
      .ev_time_q, .ev_meas_q, .ev_pickup_q, .ev_mode_q, .log_kind, .log_time, .log_meas,
      .log_count);

   stage_env_model u_stage_env_model (
      .clk, .rst_b, .ev_valid(ev_valid_q), .ev_on(ev_on_q), .ev_time(ev_time_q),
      .cycle_tick, .time_now, .n_on, .n_off, .age);

   // Compare one value; an unknown never matches
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL %0t %s", $time, what);
      end
   endtask : chk

   // Step n falling edges, ramping meas; count clocks with start high
   task automatic run(input int n, input int step, output int hits);
      hits = 0;
      repeat (n) begin
         @(negedge clk);
         if (start_q === 1'b1) hits++;
         if (step != 0) meas = meas + step;
      end
   endtask : run

   task automatic do_reset;
      int h;
      rst_b = 1'b0;
      run(10, 0, h);
      rst_b = 1'b1;
      run(2, 0, h);
   endtask : do_reset

   // Settle past two windows, then look for any pick-up
   task automatic mode_case(input cmp_mode_t m, input int v, input int step, input int p,
                            input int b, input logic e);
      int h;
      @(negedge clk);
      mode = m;
      meas = v;
      pickup = p;
      block_limit = b;
      run(36, step, h);
      run(40, step, h);
      chk(32'(h > 0), 32'(e), "comparator outcome");
   endtask : mode_case

   task automatic t_modes;
      mode_case(CMP_OVER, 200, 0, 100, 0, 1'b1);
      mode_case(CMP_OVER, -200, 0, -100, 0, 1'b0);
      mode_case(CMP_OVER, -200, 0, -300, 0, 1'b1);
      mode_case(CMP_OVER_ABS, -200, 0, 100, 0, 1'b1);
      mode_case(CMP_UNDER, 50, 0, 100, 0, 1'b1);
      mode_case(CMP_UNDER, -50, 0, 100, 0, 1'b0);
      mode_case(CMP_UNDER_ABS, -50, 0, 100, -1000, 1'b1);
      mode_case(CMP_UNDER_ABS, -50, 0, 100, 0, 1'b0);
      mode_case(CMP_DELTA_PCT, 10000, 10, 50, 0, 1'b1);
      mode_case(CMP_DELTA_PCT, 10000, -10, 50, 0, 1'b0);
      mode_case(CMP_DELTA_PCT_ABS, 10000, -10, 50, 0, 1'b1);
      mode_case(CMP_DELTA_VAL, 10000, 10, 50, 0, 1'b1);
      mode_case(CMP_DELTA_VAL, 10000, -10, 50, 0, 1'b0);
      mode_case(CMP_DELTA_VAL_ABS, 10000, -10, 50, 0, 1'b1);
      $display("test modes done");
   endtask : t_modes

   // Band is 3 % of 20000: an absolute offset would release at 19500
   task automatic t_hyst;
      int h;
      @(negedge clk);
      mode = CMP_OVER;
      pickup = 20000;
      meas = 20100;
      run(12, 0, h);
      chk(32'(start_q), 32'h1, "pick-up above level");
      meas = 19500;
      run(12, 0, h);
      chk(32'(start_q), 32'h1, "held inside band");
      meas = 19300;
      run(12, 0, h);
      chk(32'(start_q), 32'h0, "released past band");
      $display("test hysteresis done");
   endtask : t_hyst

   task automatic t_block;
      int h;
      pickup = 100;
      op_delay = 24'h000005;
      block_in = 1'b1;
      meas = 200;
      run(16, 0, h);
      chk(32'(blocked_q), 32'h1, "blocked flag");
      chk(32'(h), 32'h0, "no start while blocked");
      chk(32'(cond_q), 32'(COND_BLOCKED), "blocked code");
      block_in = 1'b0;
      run(8, 0, h);
      chk(32'(start_q), 32'h1, "start once unblocked");
      chk(32'(cond_q), 32'(COND_START), "start code");
      chk(32'(trip_q), 32'h0, "trip waits for delay");
      run(24, 0, h);
      chk(32'(trip_q), 32'h1, "trip after delay");
      chk(32'(cond_q), 32'(COND_TRIP), "trip code");
      block_in = 1'b1;
      run(8, 0, h);
      chk(32'(start_q), 32'h0, "start cleared by block");
      run(24, 0, h);
      chk(32'(trip_q), 32'h0, "trip released");
      chk({ev_mode_q, ev_meas_q[12:0], ev_pickup_q[15:0]}, 32'h00C80064, "context");
      chk(32'(n_off), 32'h0, "off events filtered");
      chk(32'(n_on > 0), 32'h1, "on events stored");
      chk(32'(age < 4), 32'h1, "event time stamp");
      ev_select = 2'h3;
      meas = 0;
      run(12, 0, h);
      chk(32'(n_off > 0), 32'h1, "off events stored");
      $display("test blocking done");
   endtask : t_block

   // Fourteen starts: only the newest twelve stay, newest at index 0
   task automatic t_log;
      int h, tn;
      do_reset();
      block_in = 1'b0;
      op_delay = 24'h00FFFF;
      for (int i = 0; i < 14; i++) begin
         meas = 200 + i;
         run(12, 0, h);
         meas = 0;
         run(12, 0, h);
      end
      chk(32'(log_count), 32'(LOG_DEPTH), "log saturates");
      log_idx = 4'h0;
      run(2, 0, h);
      chk(32'(log_meas), 32'h000000D5, "newest entry");
      chk(32'(log_kind), 32'(EVK_START), "entry kind");
      tn = log_time;
      log_idx = 4'hB;
      run(2, 0, h);
      chk(32'(log_meas), 32'h000000CA, "oldest entry");
      chk(tn - log_time, 32'h00000108, "log time order");
      $display("test log done");
   endtask : t_log

   task automatic t_freeze;
      int h;
      clk_en = 1'b0;
      meas = 300;
      run(16, 0, h);
      chk(32'(h), 32'h0, "frozen stage holds");
      clk_en = 1'b1;
      run(12, 0, h);
      chk(32'(start_q), 32'h1, "stage resumes");
      $display("test freeze done");
   endtask : t_freeze

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude

   initial begin
      rst_b = 1'b0;
      clk_en = 1'b1;
      block_in = 1'b0;
      meas = 32'h0;
      mode = CMP_OVER;
      pickup = 32'h64;
      hyst = HYST_RESET;
      block_limit = 32'h0;
      op_delay = 24'h00FFFF;
      rel_delay = 24'h000003;
      ev_select = 2'h1;
      log_idx = 4'h0;
      do_reset();
      t_modes();
      t_hyst();
      t_block();
      t_log();
      t_freeze();
      conclude();
   end
endmodule : tb_programmable_stage_block
